/* File: rtl/mdf_m12_regs.vh */
`ifndef MDF_M12_REGS_VH
`define MDF_M12_REGS_VH

`define MDF_ADDR_CTRL       4'h0
`define MDF_ADDR_TX_SEL     4'h1
`define MDF_ADDR_RX_SEL     4'h2
`define MDF_ADDR_AIS_PERIOD 4'h3
`define MDF_ADDR_MAP_TX     2'h1
`define MDF_ADDR_MAP_RX     2'h2
`define MDF_ADDR_LB_CODE    4'hC
`define MDF_ADDR_STATUS     4'hD
`define MDF_ADDR_RLOOP      4'hE
`define MDF_ADDR_BERT       4'hF

`define MDF_CTRL_G747       0
`define MDF_CTRL_AIS_TX     1
`define MDF_CTRL_LB_TX      2
`define MDF_CTRL_XBIT       3
`define MDF_CTRL_RA         4
`define MDF_CTRL_PARITY     5
`define MDF_BERT_EN         5
`define MDF_ST_IN_FRAME     0
`define MDF_ST_AIS          1
`define MDF_ST_LB_DET       2

`define MDF_CTRL_RST        6'h00
`define MDF_AIS_PERIOD_RST  8'h02
`define MDF_LB_CODE_RST     12'hAAA
`define MDF_TX_GROUP_LAST   3'h6

`define MDF_M12_LAST_BIT    6'h30
`define MDF_M12_LAST_BLK    3'h5
`define MDF_M12_LAST_SF     2'h3
`define MDF_F_NEED          4'h8
`define MDF_M_NEED          2'h3
`define MDF_G_LAST_BIT      8'hA8
`define MDF_G_LAST_SET      3'h4
`define MDF_G_FAW           9'h1D0
`define MDF_G_FAW_END       8'h09
`define MDF_G_HDR_END       8'h03
`define MDF_G_JUST_END      8'h06
`define MDF_G_SYNC_LAST     2'h2
`define MDF_G_LOF_LAST      2'h3
`define MDF_LB_REPEAT       3'h5
`define MDF_AIS_WIN_LAST    12'hC53
`define MDF_AIS_ZERO_MAX    2'h3

`endif

/* File: rtl/mdf_sel32.v */
`timescale 1ns/1ps
`default_nettype none
module mdf_sel32 (
  input  wire [31:0] i_src,
  input  wire [4:0]  i_sel,
  output wire        o_bit
);
  assign o_bit = i_src[i_sel];
endmodule
`default_nettype wire

/* File: rtl/mdf_m12_framer.v */
`timescale 1ns/1ps
`default_nettype none
`include "mdf_m12_regs.vh"
module mdf_m12_framer (
  input  wire        i_clk,
  input  wire        i_reset_n,
  input  wire [3:0]  i_addr,
  input  wire [31:0] i_wr_data,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rd_data,
  input  wire [31:0] i_ls_data,
  input  wire [31:0] i_ls_avail,
  input  wire        i_bert_data,
  output reg         o_bert_rx,
  output reg  [27:0] o_tx_trib,
  output reg  [3:0]  o_tx_take,
  input  wire        i_ds2_tx_en,
  output reg         o_ds2_tx_data,
  input  wire        i_ds2_rx_en,
  input  wire        i_ds2_rx_data,
  input  wire [23:0] i_rx_trib_ext,
  input  wire [3:0]  i_spare,
  output reg  [3:0]  o_rx_valid,
  output reg  [31:0] o_rx_port,
  output reg         o_in_frame,
  output reg         o_ais,
  output reg         o_lb_det
);
  function maj3;
    input [2:0] v;
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
  function [2:0] pop5;
    input [4:0] v;
    pop5 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]} + {2'h0, v[4]};
  endfunction

  reg [31:0] ls_meta, ls_sync, av_meta, av_sync;
  reg [5:0]  ctrl;
  reg [2:0]  tx_sel, rx_sel;
  reg [7:0]  ais_period;
  reg [11:0] lb_code;
  reg [31:0] rloop;
  reg        bert_en;
  reg [4:0]  bert_line;
  reg [4:0]  tx_map [0:27];
  reg [4:0]  rx_map [0:31];
  reg [31:0] rd_mux;
  reg [31:0] tx_src;
  reg [3:0]  rx_trib;
  wire [27:0] tx_sel_bit;
  wire [3:0]  trib_avail;
  wire [31:0] rx_sel_bit;
  wire [31:0] rx_src = {i_spare, i_rx_trib_ext, rx_trib};
  wire        g747 = ctrl[`MDF_CTRL_G747];
  integer     i;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ls_meta <= 32'h0;
      ls_sync <= 32'h0;
      av_meta <= 32'h0;
      av_sync <= 32'h0;
    end else begin
      ls_meta <= i_ls_data;
      ls_sync <= ls_meta;
      av_meta <= i_ls_avail;
      av_sync <= av_meta;
    end
  end

  // register writes; group selects outside the switch range are ignored
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl       <= `MDF_CTRL_RST;
      tx_sel     <= 3'h0;
      rx_sel     <= 3'h0;
      ais_period <= `MDF_AIS_PERIOD_RST;
      lb_code    <= `MDF_LB_CODE_RST;
      rloop      <= 32'h0;
      bert_en    <= 1'b0;
      bert_line  <= 5'h0;
      for (i = 0; i < 28; i = i + 1) begin
        tx_map[i] <= i[4:0];
      end
      for (i = 0; i < 32; i = i + 1) begin
        rx_map[i] <= i[4:0];
      end
    end else if (i_wr) begin
      if (i_addr == `MDF_ADDR_CTRL) begin
        ctrl <= i_wr_data[5:0];
      end else if (i_addr == `MDF_ADDR_TX_SEL) begin
        if (i_wr_data[2:0] <= `MDF_TX_GROUP_LAST) begin
          tx_sel <= i_wr_data[2:0];
        end
      end else if (i_addr == `MDF_ADDR_RX_SEL) begin
        rx_sel <= i_wr_data[2:0];
      end else if (i_addr == `MDF_ADDR_AIS_PERIOD) begin
        ais_period <= i_wr_data[7:0];
      end else if (i_addr[3:2] == `MDF_ADDR_MAP_TX) begin
        tx_map[{tx_sel, i_addr[1:0]}] <= i_wr_data[4:0];
      end else if (i_addr[3:2] == `MDF_ADDR_MAP_RX) begin
        rx_map[{rx_sel, i_addr[1:0]}] <= i_wr_data[4:0];
      end else if (i_addr == `MDF_ADDR_LB_CODE) begin
        lb_code <= i_wr_data[11:0];
      end else if (i_addr == `MDF_ADDR_RLOOP) begin
        rloop <= i_wr_data;
      end else if (i_addr == `MDF_ADDR_BERT) begin
        bert_en   <= i_wr_data[`MDF_BERT_EN];
        bert_line <= i_wr_data[4:0];
      end
    end
  end

  always @* begin
    rd_mux = 32'h0;
    if (i_addr == `MDF_ADDR_CTRL) begin
      rd_mux = {26'h0, ctrl};
    end else if (i_addr == `MDF_ADDR_TX_SEL) begin
      rd_mux = {29'h0, tx_sel};
    end else if (i_addr == `MDF_ADDR_RX_SEL) begin
      rd_mux = {29'h0, rx_sel};
    end else if (i_addr == `MDF_ADDR_AIS_PERIOD) begin
      rd_mux = {24'h0, ais_period};
    end else if (i_addr[3:2] == `MDF_ADDR_MAP_TX) begin
      rd_mux = {27'h0, tx_map[{tx_sel, i_addr[1:0]}]};
    end else if (i_addr[3:2] == `MDF_ADDR_MAP_RX) begin
      rd_mux = {27'h0, rx_map[{rx_sel, i_addr[1:0]}]};
    end else if (i_addr == `MDF_ADDR_LB_CODE) begin
      rd_mux = {20'h0, lb_code};
    end else if (i_addr == `MDF_ADDR_STATUS) begin
      rd_mux = {29'h0, o_lb_det, o_ais, o_in_frame};
    end else if (i_addr == `MDF_ADDR_RLOOP) begin
      rd_mux = rloop;
    end else begin
      rd_mux = {26'h0, bert_en, bert_line};
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 32'h0;
    end else begin
      o_rd_data <= i_rd ? rd_mux : 32'h0;
    end
  end

  // tester line replaces the selected input ahead of the switches
  always @* begin
    tx_src = ls_sync;
    if (bert_en) begin
      tx_src[bert_line] = i_bert_data;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 28; g = g + 1) begin : g_tx
      mdf_sel32 u_sel (.i_src(tx_src), .i_sel(tx_map[g]), .o_bit(tx_sel_bit[g]));
    end
    for (g = 0; g < 4; g = g + 1) begin : g_av
      mdf_sel32 u_sel (.i_src(av_sync), .i_sel(tx_map[g]), .o_bit(trib_avail[g]));
    end
    for (g = 0; g < 32; g = g + 1) begin : g_rx
      mdf_sel32 u_sel (.i_src(rx_src), .i_sel(rx_map[g]), .o_bit(rx_sel_bit[g]));
    end
  endgenerate

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_tx_trib <= 28'h0;
      o_rx_port <= 32'h0;
      o_bert_rx <= 1'b0;
    end else begin
      o_tx_trib <= tx_sel_bit;
      o_rx_port <= (rloop & ls_sync) | (~rloop & rx_sel_bit);
      o_bert_rx <= ls_sync[bert_line];
    end
  end

  // transmit multiplexer
  reg  [1:0] tx_sf;
  reg  [2:0] tx_blk;
  reg  [5:0] tx_bit;
  reg  [2:0] tx_set;
  reg  [7:0] tx_gbit;
  reg  [1:0] tx_grot;
  reg  [3:0] tx_stuff;
  reg        tx_val;
  reg  [3:0] tx_take;
  wire [5:0] tx_tb1 = tx_bit - 6'h1;
  wire [1:0] tx_ck  = (tx_blk == 3'h1) ? 2'h0 : ((tx_blk == 3'h3) ? 2'h1 : 2'h2);
  wire [3:0] tx_cidx = {1'b0, tx_sf, 1'b0} + {2'h0, tx_sf} + {2'h0, tx_ck};
  wire       tx_ginfo = !((tx_set == 3'h0) && (tx_gbit <= `MDF_G_FAW_END)) &&
                        !((tx_set != 3'h0) && (tx_gbit <= `MDF_G_HDR_END));
  wire [8:0] faw = `MDF_G_FAW;

  always @* begin
    tx_val  = 1'b0;
    tx_take = 4'h0;
    if (ctrl[`MDF_CTRL_AIS_TX]) begin
      tx_val = 1'b1;
    end else if (g747) begin
      if ((tx_set == 3'h0) && (tx_gbit <= `MDF_G_FAW_END)) begin
        tx_val = faw[4'h9 - tx_gbit[3:0]];
      end else if ((tx_set == 3'h1) && (tx_gbit <= `MDF_G_HDR_END)) begin
        if (tx_gbit == 8'h01) begin
          tx_val = ctrl[`MDF_CTRL_RA];
        end else if (tx_gbit == 8'h02) begin
          tx_val = ctrl[`MDF_CTRL_PARITY];
        end else begin
          tx_val = 1'b1;
        end
      end else if (tx_gbit <= `MDF_G_HDR_END) begin
        tx_val = tx_stuff[tx_gbit[1:0] - 2'h1];
      end else if ((tx_set == `MDF_G_LAST_SET) && (tx_gbit <= `MDF_G_JUST_END) &&
                   tx_stuff[tx_grot]) begin
        tx_val = 1'b0;
      end else begin
        tx_val           = o_tx_trib[tx_grot];
        tx_take[tx_grot] = 1'b1;
      end
    end else if (tx_bit == 6'h0) begin
      case (tx_blk)
        3'h0: tx_val = (tx_sf == `MDF_M12_LAST_SF) ? ctrl[`MDF_CTRL_XBIT] :
                       (tx_sf != 2'h0);
        3'h2: tx_val = 1'b0;
        3'h5: tx_val = 1'b1;
        default: tx_val = ctrl[`MDF_CTRL_LB_TX] ? lb_code[tx_cidx] :
                          tx_stuff[tx_sf];
      endcase
    end else if ((tx_blk == `MDF_M12_LAST_BLK) && (tx_bit == {4'h0, tx_sf} + 6'h1) &&
                 tx_stuff[tx_sf]) begin
      tx_val = 1'b0;
    end else begin
      tx_val                 = o_tx_trib[tx_tb1[1:0]] ^ tx_tb1[0];
      tx_take[tx_tb1[1:0]]   = 1'b1;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_sf         <= 2'h0;
      tx_blk        <= 3'h0;
      tx_bit        <= 6'h0;
      tx_set        <= 3'h0;
      tx_gbit       <= 8'h01;
      tx_grot       <= 2'h0;
      tx_stuff      <= 4'h0;
      o_ds2_tx_data <= 1'b1;
      o_tx_take     <= 4'h0;
    end else begin
      o_tx_take <= 4'h0;
      if (i_ds2_tx_en) begin
        o_ds2_tx_data <= tx_val;
        o_tx_take     <= tx_take;
        if (tx_bit == `MDF_M12_LAST_BIT) begin
          tx_bit <= 6'h0;
          if (tx_blk == `MDF_M12_LAST_BLK) begin
            tx_blk <= 3'h0;
            tx_sf  <= tx_sf + 2'h1;
          end else begin
            tx_blk <= tx_blk + 3'h1;
          end
        end else begin
          tx_bit <= tx_bit + 6'h1;
        end
        if (tx_gbit == `MDF_G_LAST_BIT) begin
          tx_gbit <= 8'h01;
          tx_grot <= 2'h0;
          tx_set  <= (tx_set == `MDF_G_LAST_SET) ? 3'h0 : tx_set + 3'h1;
        end else begin
          tx_gbit <= tx_gbit + 8'h01;
          if (tx_ginfo) begin
            tx_grot <= (tx_grot == 2'h2) ? 2'h0 : tx_grot + 2'h1;
          end
        end
        if (g747 ? ((tx_set == `MDF_G_LAST_SET) && (tx_gbit == `MDF_G_LAST_BIT)) :
            ((tx_sf == `MDF_M12_LAST_SF) && (tx_blk == `MDF_M12_LAST_BLK) &&
             (tx_bit == `MDF_M12_LAST_BIT))) begin
          tx_stuff <= g747 ? (~trib_avail & 4'h7) : ~trib_avail;
        end
      end
    end
  end

  // receive framer and demultiplexer
  reg  [1:0]  rx_sf;
  reg  [2:0]  rx_blk;
  reg  [5:0]  rx_bit;
  reg  [2:0]  rx_set;
  reg  [7:0]  rx_gbit;
  reg  [1:0]  rx_grot;
  reg  [3:0]  fcnt;
  reg  [1:0]  mcnt;
  reg  [4:0]  fhist;
  reg  [3:0]  mhist;
  reg  [11:0] rx_c;
  reg  [8:0]  faw_sr;
  reg  [1:0]  g_cnt;
  reg  [1:0]  g_miss;
  reg  [2:0]  lb_cnt;
  reg  [11:0] ais_bits;
  reg  [1:0]  ais_zero;
  reg  [7:0]  ais_win;
  wire        d       = i_ds2_rx_data;
  wire        rx_oh   = (rx_bit == 6'h0);
  wire        rx_fpos = rx_oh && ((rx_blk == 3'h2) || (rx_blk == 3'h5));
  wire        rx_ferr = (d != (rx_blk == 3'h5));
  wire        rx_mpos = rx_oh && (rx_blk == 3'h0) && (rx_sf != `MDF_M12_LAST_SF);
  wire        rx_merr = (d != (rx_sf != 2'h0));
  wire        rx_cpos = rx_oh && ((rx_blk == 3'h1) || (rx_blk == 3'h3) || (rx_blk == 3'h4));
  wire [1:0]  rx_ck   = (rx_blk == 3'h1) ? 2'h0 : ((rx_blk == 3'h3) ? 2'h1 : 2'h2);
  wire [3:0]  rx_cb   = {1'b0, rx_sf, 1'b0} + {2'h0, rx_sf};
  wire [3:0]  rx_gcb  = {1'b0, rx_grot, 1'b0} + {2'h0, rx_grot};
  wire [5:0]  rx_tb1  = rx_bit - 6'h1;
  wire [4:0]  fh_next = {fhist[3:0], rx_ferr};
  wire [3:0]  mh_next = {mhist[2:0], rx_merr};
  wire        faw_ok  = ({faw_sr[7:0], d} == `MDF_G_FAW);
  wire        g_hdr   = (rx_gbit <= ((rx_set == 3'h0) ? `MDF_G_FAW_END : `MDF_G_HDR_END));
  wire        m_end   = (rx_sf == `MDF_M12_LAST_SF) && (rx_blk == `MDF_M12_LAST_BLK) &&
                        (rx_bit == `MDF_M12_LAST_BIT);
  wire        m_slip  = !g747 && !o_in_frame && rx_fpos && rx_ferr;

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_sf      <= 2'h0;
      rx_blk     <= 3'h0;
      rx_bit     <= 6'h0;
      rx_set     <= 3'h0;
      rx_gbit    <= 8'h01;
      rx_grot    <= 2'h0;
      fcnt       <= 4'h0;
      mcnt       <= 2'h0;
      fhist      <= 5'h0;
      mhist      <= 4'h0;
      rx_c       <= 12'h0;
      faw_sr     <= 9'h0;
      g_cnt      <= 2'h0;
      g_miss     <= 2'h0;
      lb_cnt     <= 3'h0;
      rx_trib    <= 4'h0;
      o_rx_valid <= 4'h0;
      o_in_frame <= 1'b0;
      o_lb_det   <= 1'b0;
    end else begin
      o_rx_valid <= 4'h0;
      if (i_ds2_rx_en) begin
        faw_sr <= {faw_sr[7:0], d};
        if (!m_slip) begin
          if (rx_bit == `MDF_M12_LAST_BIT) begin
            rx_bit <= 6'h0;
            if (rx_blk == `MDF_M12_LAST_BLK) begin
              rx_blk <= 3'h0;
              rx_sf  <= rx_sf + 2'h1;
            end else begin
              rx_blk <= rx_blk + 3'h1;
            end
          end else begin
            rx_bit <= rx_bit + 6'h1;
            if (!o_in_frame && rx_mpos && rx_merr) begin
              rx_sf <= rx_sf + 2'h1;
            end
          end
        end
        if (g747 && (g_cnt == 2'h0) && !o_in_frame && faw_ok) begin
          rx_set  <= 3'h0;
          rx_gbit <= `MDF_G_FAW_END + 8'h01;
          rx_grot <= 2'h0;
          g_cnt   <= 2'h1;
        end else if (rx_gbit == `MDF_G_LAST_BIT) begin
          rx_gbit <= 8'h01;
          rx_grot <= 2'h0;
          rx_set  <= (rx_set == `MDF_G_LAST_SET) ? 3'h0 : rx_set + 3'h1;
        end else begin
          rx_gbit <= rx_gbit + 8'h01;
          if (!g_hdr) begin
            rx_grot <= (rx_grot == 2'h2) ? 2'h0 : rx_grot + 2'h1;
          end
        end
        if (g747) begin
          if ((rx_set == 3'h0) && (rx_gbit == `MDF_G_FAW_END) &&
              ((g_cnt != 2'h0) || o_in_frame)) begin
            if (faw_ok) begin
              g_miss <= 2'h0;
              if (!o_in_frame) begin
                g_cnt <= g_cnt + 2'h1;
                if (g_cnt == `MDF_G_SYNC_LAST) begin
                  o_in_frame <= 1'b1;
                end
              end
            end else if (!o_in_frame) begin
              g_cnt <= 2'h0;
            end else if (g_miss == `MDF_G_LOF_LAST) begin
              o_in_frame <= 1'b0;
              g_cnt      <= 2'h0;
              g_miss     <= 2'h0;
            end else begin
              g_miss <= g_miss + 2'h1;
            end
          end
          if ((rx_set >= 3'h2) && (rx_gbit <= `MDF_G_HDR_END) && (rx_gbit != 8'h0)) begin
            rx_c[{1'b0, rx_gbit[1:0] - 2'h1, 1'b0} + {2'h0, rx_gbit[1:0] - 2'h1} +
                 {1'b0, rx_set - 3'h2}] <= d;
          end
          if (o_in_frame && !g_hdr) begin
            if (!((rx_set == `MDF_G_LAST_SET) && (rx_gbit <= `MDF_G_JUST_END) &&
                  maj3(rx_c[rx_gcb +: 3]))) begin
              rx_trib[rx_grot]    <= d;
              o_rx_valid[rx_grot] <= 1'b1;
            end
          end
        end else begin
          if (!o_in_frame) begin
            if (rx_fpos) begin
              fcnt <= rx_ferr ? 4'h0 : ((fcnt == `MDF_F_NEED) ? fcnt : fcnt + 4'h1);
            end
            if (rx_mpos) begin
              mcnt <= rx_merr ? 2'h0 : ((mcnt == `MDF_M_NEED) ? mcnt : mcnt + 2'h1);
            end
            if ((fcnt == `MDF_F_NEED) && (mcnt == `MDF_M_NEED)) begin
              o_in_frame <= 1'b1;
              fhist      <= 5'h0;
              mhist      <= 4'h0;
            end
          end else begin
            if (rx_fpos) begin
              fhist <= fh_next;
              if ((pop5({1'b0, fh_next[3:0]}) >= 3'h2) || (pop5(fh_next) >= 3'h3)) begin
                o_in_frame <= 1'b0;
                fcnt       <= 4'h0;
                mcnt       <= 2'h0;
              end
            end
            if (rx_mpos) begin
              mhist <= mh_next;
              if (pop5({1'b0, mh_next}) >= 3'h3) begin
                o_in_frame <= 1'b0;
                fcnt       <= 4'h0;
                mcnt       <= 2'h0;
              end
            end
          end
          if (rx_cpos) begin
            rx_c[rx_cb + {2'h0, rx_ck}] <= d;
          end
          if (o_in_frame && !rx_oh) begin
            if (!((rx_blk == `MDF_M12_LAST_BLK) && (rx_bit == {4'h0, rx_sf} + 6'h1) &&
                  maj3(rx_c[rx_cb +: 3]))) begin
              rx_trib[rx_tb1[1:0]]    <= d ^ rx_tb1[0];
              o_rx_valid[rx_tb1[1:0]] <= 1'b1;
            end
          end
          if (m_end && o_in_frame) begin
            if ({rx_c[11:1], d} == lb_code || rx_c == lb_code) begin
              lb_cnt <= (lb_cnt == `MDF_LB_REPEAT) ? lb_cnt : lb_cnt + 3'h1;
              if (lb_cnt >= `MDF_LB_REPEAT - 3'h1) begin
                o_lb_det <= 1'b1;
              end
            end else begin
              lb_cnt   <= 3'h0;
              o_lb_det <= 1'b0;
            end
          end
        end
      end
    end
  end

  // ais: count windows of mostly ones while out of frame
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ais_bits <= 12'h0;
      ais_zero <= 2'h0;
      ais_win  <= 8'h0;
      o_ais    <= 1'b0;
    end else if (o_in_frame) begin
      ais_bits <= 12'h0;
      ais_zero <= 2'h0;
      ais_win  <= 8'h0;
      o_ais    <= 1'b0;
    end else if (i_ds2_rx_en) begin
      if (ais_bits == `MDF_AIS_WIN_LAST) begin
        ais_bits <= 12'h0;
        ais_zero <= 2'h0;
        if ((ais_zero == `MDF_AIS_ZERO_MAX) || ((ais_zero == 2'h2) && !d)) begin
          ais_win <= 8'h0;
          o_ais   <= 1'b0;
        end else begin
          ais_win <= (ais_win == 8'hFF) ? ais_win : ais_win + 8'h01;
          if (ais_win + 8'h01 >= ais_period) begin
            o_ais <= 1'b1;
          end
        end
      end else begin
        ais_bits <= ais_bits + 12'h001;
        if (!d && (ais_zero != `MDF_AIS_ZERO_MAX)) begin
          ais_zero <= ais_zero + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/mdf_m12_framer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mdf_framer_chk (
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic [3:0]  i_addr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rd_data,
  input wire logic        i_ds2_tx_en,
  input wire logic        o_ds2_tx_data,
  input wire logic [3:0]  o_tx_take,
  input wire logic        i_ds2_rx_en,
  input wire logic [3:0]  o_rx_valid,
  input wire logic        o_in_frame,
  input wire logic        o_ais,
  input wire logic        o_lb_det
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  rd_idle_zero_a: assert property (
    !$past(i_rd) |-> o_rd_data == 32'h0) else $error("read data not zero when idle");
  status_read_a: assert property (
    i_rd && i_addr == 4'hD |=> o_rd_data[2:0] == {$past(o_lb_det), $past(o_ais), $past(o_in_frame)})
    else $error("status read does not match flags");
  take_cause_a: assert property (
    o_tx_take != 4'h0 |-> $past(i_ds2_tx_en) && $onehot(o_tx_take))
    else $error("tributary take without bit request");
  tx_hold_a: assert property (
    !$past(i_ds2_tx_en) |-> $stable(o_ds2_tx_data)) else $error("tx bit moved without request");
  valid_cause_a: assert property (
    o_rx_valid != 4'h0 |-> $past(i_ds2_rx_en) && ($past(o_in_frame) || o_in_frame))
    else $error("recovered bit without received bit in frame");
  ais_rise_a: assert property (
    $rose(o_ais) |-> !$past(o_in_frame)) else $error("ais raised while in frame");
  ais_clear_a: assert property (
    o_ais && o_in_frame |=> !o_ais) else $error("ais kept while in frame");
  lb_rise_a: assert property (
    $rose(o_lb_det) |-> $past(o_in_frame)) else $error("loopback flagged out of frame");
endmodule
`default_nettype wire

/* File: bench/mdf_m23_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mdf_m23_model (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_go,
  input  wire logic i_tx_bit,
  output var  logic o_tx_en,
  output var  logic o_rx_en,
  output var  logic o_rx_bit
);
  logic [2:0] lf;
  logic       take;
  // requests at an uneven pace, received stream mirrors the sent one
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      lf <= 3'h4;
      take <= 1'b0;
      o_tx_en <= 1'b0;
      o_rx_en <= 1'b0;
      o_rx_bit <= 1'b0;
    end else begin
      lf <= {lf[1:0], lf[2] ^ lf[1]};
      o_tx_en <= i_go & (lf[0] | lf[2]);
      take <= o_tx_en;
      o_rx_en <= take;
      // toggles between bits so a stale value never looks valid
      o_rx_bit <= take ? i_tx_bit : ~o_rx_bit;
    end
  end
endmodule
`default_nettype wire

/* File: bench/mdf_m12_framer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module mdf_m12_framer_tb_top;
  logic        i_clk, i_reset_n, wr, rd, go, chk, en_d, tx_en, rx_en, rx_bit;
  logic        bert, txd, inf, ais, lbd;
  logic [3:0]  addr, take, rxv, spare;
  logic [31:0] wd, ls, avail, lf, rdata, port;
  logic [23:0] ext;
  logic [27:0] trib;
  logic [4:0]  sel [4];
  int          n_errors, checks, cyc, nbit;
  mdf_m12_framer u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(addr), .i_wr_data(wd),
    .i_wr(wr), .i_rd(rd), .o_rd_data(rdata), .i_ls_data(ls), .i_ls_avail(avail),
    .i_bert_data(ls[31]), .o_bert_rx(bert), .o_tx_trib(trib), .o_tx_take(take),
    .i_ds2_tx_en(tx_en), .o_ds2_tx_data(txd), .i_ds2_rx_en(rx_en), .i_ds2_rx_data(rx_bit),
    .i_rx_trib_ext(ext), .i_spare(spare), .o_rx_valid(rxv), .o_rx_port(port),
    .o_in_frame(inf), .o_ais(ais), .o_lb_det(lbd));
  mdf_m23_model u_far (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_go(go), .i_tx_bit(txd),
    .o_tx_en(tx_en), .o_rx_en(rx_en), .o_rx_bit(rx_bit));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // X bit set, tributary 2 short of data, others full
  function automatic logic m12_bit(input int n);
    int p, sf, blk, b, t;
    p = n % 1176;
    sf = p / 294;
    blk = (p % 294) / 49;
    b = p % 49;
    t = (b + 3) % 4;
    if (b == 0)
      return blk == 0 ? sf != 0 : blk == 2 ? 1'b0 : blk == 5 ? 1'b1 : sf == 2;
    if (blk == 5 && sf == 2 && b == 3)
      return 1'b0;
    return ls[t] ^ t[0];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checks++;
    if (got !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] want);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    cmp(rdata, want);
    @(posedge i_clk);
  endtask
  task automatic summarize;
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    en_d <= tx_en;
    if (!i_reset_n)
      nbit <= 0;
    else if (en_d) begin
      if (chk && nbit >= 1176)
        cmp(32'(txd), 32'(m12_bit(nbit)));
      nbit <= nbit + 1;
    end
    if (cyc == 90000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {i_reset_n, wr, rd, go, chk, en_d, addr, wd, cyc} = '0;
    lf = 32'h4;
    ls = lf;
    avail = '1;
    ext = lf[23:0];
    spare = 4'h0;
    repeat (4) @(posedge i_clk);
    i_reset_n <= 1'b1;
    lf = nxt(nxt(lf));
    ls <= lf;
    ext <= lf[31:8];
    spare <= lf[3:0];
    repeat (5) @(posedge i_clk);
    cmp(32'(trib), 32'(ls[27:0]));
    cmp(port[31:4], {4'h0, spare, ext});
    rreg(4'h0, 32'h0);
    rreg(4'h3, 32'h2);
    rreg(4'hC, 32'hAAA);
    wreg(4'h1, 32'h2);
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      sel[k] = lf[4:0];
      wreg(4'h4 + 4'(k), 32'(sel[k]));
    end
    wreg(4'h1, 32'h7);
    rreg(4'h1, 32'h2);
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 4; k++)
      cmp(32'(trib[8 + k]), 32'(ls[sel[k]]));
    wreg(4'h2, 32'h3);
    for (int k = 0; k < 4; k++) begin
      lf = nxt(lf);
      sel[k] = 5'(4 + lf % 28);
      wreg(4'h8 + 4'(k), 32'(sel[k]));
    end
    repeat (4) @(posedge i_clk);
    for (int k = 0; k < 4; k++)
      cmp(32'(port[12 + k]), 32'({spare, ext} >> (sel[k] - 5'h4)) & 32'h1);
    wreg(4'hE, 32'h0010_0000);
    wreg(4'hF, 32'h26);
    repeat (4) @(posedge i_clk);
    cmp(32'(port[20]), 32'(ls[20]));
    cmp(32'(bert), 32'(ls[6]));
    cmp(32'(trib[6]), 32'(ls[31]));
    wreg(4'hF, 32'h0);
    wreg(4'h0, 32'h8);
    avail <= ~32'h4;
    chk <= 1'b1;
    go <= 1'b1;
    for (int i = 0; i < 20000 && inf !== 1'b1; i++)
      @(posedge i_clk);
    cmp(32'(inf), 32'h1);
    wait (nbit > 3 * 1176);
    @(posedge i_clk);
    cmp(32'(port[3:0]), 32'(ls[3:0]));
    rreg(4'hD, 32'h1);
    chk <= 1'b0;
    wreg(4'h0, 32'hC);
    for (int i = 0; i < 20000 && lbd !== 1'b1; i++)
      @(posedge i_clk);
    cmp(32'(lbd), 32'h1);
    wreg(4'h0, 32'h2);
    for (int i = 0; i < 30000 && ais !== 1'b1; i++)
      @(posedge i_clk);
    cmp(32'(inf), 32'h0);
    cmp(32'(ais), 32'h1);
    // g747 with alarm and parity bits set; new line data so stale bits differ
    ls <= ~ls;
    wreg(4'h0, 32'h31);
    for (int i = 0; i < 20000 && inf !== 1'b1; i++)
      @(posedge i_clk);
    cmp(32'(inf), 32'h1);
    repeat (400) @(posedge i_clk);
    cmp(32'(ais), 32'h0);
    cmp(32'(port[2:0]), 32'(ls[2:0]));
    summarize();
  end
endmodule
bind mdf_m12_framer mdf_framer_chk u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
  .i_rd(i_rd), .o_rd_data(o_rd_data), .i_ds2_tx_en(i_ds2_tx_en), .o_ds2_tx_data(o_ds2_tx_data),
  .o_tx_take(o_tx_take), .i_ds2_rx_en(i_ds2_rx_en), .o_rx_valid(o_rx_valid),
  .o_in_frame(o_in_frame), .o_ais(o_ais), .o_lb_det(o_lb_det));
`default_nettype wire
